/* hdl/semr_mux_if.sv */
// handshake between the control registers and the mux sequencer
// assumes both ends on pclk
interface semr_mux_if;
    logic start;
    logic done;
    modport ctrl (output start, input done);
    modport seq  (input start, output done);
endinterface

/* hdl/semr_mux_seq.sv */
// sensor multiplexer configuration sequencer
// assumes start is a single-cycle pulse on pclk
module semr_mux_seq
    import semr_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic osc_on,
    semr_mux_if.seq   mux
);
    semr_mux_state_t st_r, st_nxt;
    logic [4:0]      cnt_r, cnt_nxt;

    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            SEMR_MUX_IDLE:
            begin
                cnt_nxt = 5'h00;
                if (mux.start)
                    st_nxt = SEMR_MUX_BUSY;
            end
            SEMR_MUX_BUSY:
            begin
                // the sequencer only advances while the oscillator runs
                if (osc_on)
                begin
                    if (cnt_r == SEMR_MUX_CNT_LAST)
                        st_nxt = SEMR_MUX_DONE;
                    else
                        cnt_nxt = cnt_r + 5'h01;
                end
            end
            SEMR_MUX_DONE:
                st_nxt = SEMR_MUX_IDLE;
            default:
                st_nxt = SEMR_MUX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r  <= SEMR_MUX_IDLE;
            cnt_r <= 5'h00;
        end
        else if (clk_en)
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign mux.done = (st_r == SEMR_MUX_DONE);
endmodule

/* hdl/semr_pkg.sv */
// package of the sensor enable / pin / led register bank
// assumes a single pclk domain and apb word addressing
package semr_pkg;
    // ==========================================================
    // register byte addresses (printed offsets are indices)
    localparam logic [7:0] SEMR_IDX_POWER_MEASURE = 8'h80;
    localparam logic [7:0] SEMR_IDX_GENERAL_PIN   = 8'h6b;
    localparam logic [7:0] SEMR_IDX_LED_CURRENT_CODE     = 8'hcd;
    localparam logic [9:0] SEMR_ADDR_POWER_MEASURE = {SEMR_IDX_POWER_MEASURE, 2'b00};
    localparam logic [9:0] SEMR_ADDR_GENERAL_PIN   = {SEMR_IDX_GENERAL_PIN, 2'b00};
    localparam logic [9:0] SEMR_ADDR_LED_CURRENT_CODE     = {SEMR_IDX_LED_CURRENT_CODE, 2'b00};
    localparam int SEMR_ADDR_W = 10;

    // ==========================================================
    // field positions
    localparam int SEMR_BIT_POWER_ON     = 0;
    localparam int SEMR_BIT_SPECTRAL_EN  = 1;
    localparam int SEMR_BIT_WAIT_EN      = 3;
    localparam int SEMR_BIT_MUX_START    = 4;
    localparam int SEMR_BIT_PIN_IN       = 0;
    localparam int SEMR_BIT_PIN_OUT      = 1;
    localparam int SEMR_BIT_PIN_IN_EN    = 2;
    localparam int SEMR_BIT_PIN_INV      = 3;
    localparam int SEMR_BIT_LED_ON       = 7;

    // ==========================================================
    // reset values
    localparam logic [7:0] SEMR_RST_POWER_MEASURE = 8'h00;
    localparam logic [3:0] SEMR_RST_GENERAL_PIN   = 4'h2;
    localparam logic [7:0] SEMR_RST_LED_CURRENT_CODE     = 8'h04;

    // ==========================================================
    // multiplexer sequencer timing
    localparam int SEMR_MUX_CYCLES = 16;
    localparam logic [4:0] SEMR_MUX_CNT_LAST = 5'(SEMR_MUX_CYCLES - 1);

    typedef enum logic [1:0]
    {
        SEMR_MUX_IDLE = 2'b00,
        SEMR_MUX_BUSY = 2'b01,
        SEMR_MUX_DONE = 2'b10
    } semr_mux_state_t;
endpackage

/* hdl/semr_regs.sv */
// sensor enable, general pin and led_current_code register bank on apb
// assumes apb3 master on pclk; gpio pin is asynchronous to pclk
//
// What this block does
// - power-on bit starts the internal oscillator, clearing it disables the device.
// - enable bit 1 turns spectral measurement on or off and resets to 0.
// - enable bit 4 starts a mux command and clears itself when the command finishes.
// - enable bit 3 inserts a wait between consecutive measurements.
// - pin control bit 3 inverts the general-purpose output and resets to 0.
// - pin control bit 2 makes the pin an input and resets to 0.
// - pin control bit 1 resets to 1 and drives the pin active directly.
// - pin control bit 0 reads the synchronised pin level while input is enabled.
// - led bit 7 turns the led driver output on and resets to 0.
// - the 7-bit led code sets 4 mA plus 2 mA per step and resets to code 4.
module semr_regs
    import semr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             osc_enable,
    output logic             spectral_measure_enable,
    output logic             wait_enable,
    output logic             sensor_mux_busy,
    input  wire logic        gpio_i,
    output logic             gpio_o,
    output logic             gpio_oe_n,
    output logic             led_driver_pin,
    output logic      [6:0]  led_current_code
);
    // ==========================================================
    // apb decode
    logic acc;
    logic wr;
    logic hit_pm;
    logic hit_pin;
    logic hit_led;
    logic hit_any;

    assign acc     = psel && penable;
    assign hit_pm  = paddr[SEMR_ADDR_W-1:0] == SEMR_ADDR_POWER_MEASURE;
    assign hit_pin = paddr[SEMR_ADDR_W-1:0] == SEMR_ADDR_GENERAL_PIN;
    assign hit_led = paddr[SEMR_ADDR_W-1:0] == SEMR_ADDR_LED_CURRENT_CODE;
    // upper address bits must be zero for a hit
    assign hit_any = (paddr[31:SEMR_ADDR_W] == '0) && (hit_pm || hit_pin || hit_led);
    assign wr      = acc && pwrite && hit_any && clk_en;
    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc && !hit_any;

    // ==========================================================
    // pin synchroniser
    logic sync1_r;
    logic sync2_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sync1_r <= gpio_i;
            sync2_r <= sync1_r;
        end
    end

    // ==========================================================
    // mux sequencer
    semr_mux_if mux_if ();

    semr_mux_seq u_mux_seq
    (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .osc_on  (osc_enable),
        .mux     (mux_if.seq)
    );

    // ==========================================================
    // register state
    logic [7:0] pm_r, pm_nxt;
    logic [3:0] pin_r, pin_nxt;
    logic [7:0] led_r, led_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic       mux_start;

    always_comb
    begin
        pm_nxt    = pm_r;
        pin_nxt   = pin_r;
        led_nxt   = led_r;
        mux_start = 1'b0;
        if (wr && hit_pm)
        begin
            pm_nxt = pwdata[7:0];
            // a running command is not restarted; the bit stays set until it finishes
            if (pwdata[SEMR_BIT_MUX_START] && !pm_r[SEMR_BIT_MUX_START])
                mux_start = 1'b1;
            else if (pm_r[SEMR_BIT_MUX_START])
                pm_nxt[SEMR_BIT_MUX_START] = 1'b1;
        end
        if (wr && hit_pin)
            pin_nxt = {pwdata[3:1], 1'b0};
        if (wr && hit_led)
            led_nxt = pwdata[7:0];
        // completion clears the start bit; done never meets a fresh start
        if (mux_if.done)
            pm_nxt[SEMR_BIT_MUX_START] = 1'b0;
        // input bit is a live view of the synchronised pin while the input enable bit is set, else 0
        pin_nxt[SEMR_BIT_PIN_IN] = pin_nxt[SEMR_BIT_PIN_IN_EN] && sync2_r;
    end

    assign mux_if.start = mux_start;

    always_comb
    begin
        rd_nxt = 8'h00;
        if (psel && !penable && !pwrite)
        begin
            if (hit_any && hit_pm)
                rd_nxt = pm_r;
            else if (hit_any && hit_pin)
                rd_nxt = {4'h0, pin_r};
            else if (hit_any && hit_led)
                rd_nxt = led_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pm_r  <= SEMR_RST_POWER_MEASURE;
            pin_r <= SEMR_RST_GENERAL_PIN;
            led_r <= SEMR_RST_LED_CURRENT_CODE;
            rd_r  <= 8'h00;
        end
        else if (clk_en)
        begin
            pm_r  <= pm_nxt;
            pin_r <= pin_nxt;
            led_r <= led_nxt;
            rd_r  <= rd_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = {24'h000000, rd_r};
    assign osc_enable              = pm_r[SEMR_BIT_POWER_ON];
    // measurement only acts while powered; wait follows its enable bit alone
    assign spectral_measure_enable = pm_r[SEMR_BIT_POWER_ON] && pm_r[SEMR_BIT_SPECTRAL_EN];
    assign wait_enable             = pm_r[SEMR_BIT_WAIT_EN];
    assign sensor_mux_busy         = pm_r[SEMR_BIT_MUX_START];
    assign gpio_o    = pin_r[SEMR_BIT_PIN_OUT] ^ pin_r[SEMR_BIT_PIN_INV];
    assign gpio_oe_n = pin_r[SEMR_BIT_PIN_IN_EN];
    assign led_driver_pin   = pm_r[SEMR_BIT_POWER_ON] && led_r[SEMR_BIT_LED_ON];
    assign led_current_code = led_r[6:0];
endmodule

/* test/semr_host.sv */
// apb master standing in for the host processor
// assumes an apb slave on pclk that may insert wait states
module semr_host
(
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] paddr,
    output logic      [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // ====
    // one transfer, held until pready is seen high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        // released lines show garbage rather than the old value
        {psel, penable, paddr, pwdata} <= {1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

/* test/semr_regs_props.sv */
// port checks of the register bank
// assumes it is bound onto semr_regs, one pclk domain
module semr_regs_props
    import semr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        osc_enable,
    input wire logic        spectral_measure_enable,
    input wire logic        wait_enable,
    input wire logic        sensor_mux_busy,
    input wire logic        gpio_o,
    input wire logic        gpio_oe_n,
    input wire logic        led_driver_pin,
    input wire logic [6:0]  led_current_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // write and read decode
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite && clk_en;
    wire rd_pin = psel && penable && !pwrite && paddr == SEMR_ADDR_GENERAL_PIN;
    wire wr_pin = wr && paddr == SEMR_ADDR_GENERAL_PIN;
    wire wr_led = wr && paddr == SEMR_ADDR_LED_CURRENT_CODE;
    sequence pm_wr;
        wr && paddr == SEMR_ADDR_POWER_MEASURE;
    endsequence
    sequence mux_go;
        pm_wr ##0 (pwdata[4] && pwdata[0]);
    endsequence
    // ====
    // properties
    osc_follow_a: assert property (pm_wr |=> osc_enable == $past(pwdata[0]))
        else $error("power-on bit not followed");
    spec_follow_a: assert property (pm_wr |=>
        spectral_measure_enable == ($past(pwdata[1]) && $past(pwdata[0])))
        else $error("spectral enable not followed");
    wait_follow_a: assert property (pm_wr |=> wait_enable == $past(pwdata[3]))
        else $error("wait enable not followed");
    // a stalled oscillator would hold the command, so the bound assumes power stays on
    mux_clear_a: assert property (mux_go |=> sensor_mux_busy ##[1:40] !sensor_mux_busy)
        else $error("mux start bit did not clear");
    led_follow_a: assert property (wr_led |=> led_current_code == $past(pwdata[6:0])
        && led_driver_pin == ($past(pwdata[7]) && osc_enable))
        else $error("led outputs not followed");
    pin_drive_a: assert property (wr_pin |=> gpio_oe_n == $past(pwdata[2])
        && gpio_o == ($past(pwdata[1]) ^ $past(pwdata[3])))
        else $error("pin drive not followed");
    pin_read_a: assert property (rd_pin && !gpio_oe_n |-> !prdata[0] && !prdata[2])
        else $error("pin input read while disabled");
    reset_vals_a: assert property ($rose(presetn) |-> gpio_o && !gpio_oe_n
        && led_current_code == 7'h04 && !osc_enable && !sensor_mux_busy)
        else $error("wrong value after reset");
endmodule
bind semr_regs semr_regs_props props_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .osc_enable, .spectral_measure_enable, .wait_enable,
    .sensor_mux_busy, .gpio_o, .gpio_oe_n, .led_driver_pin, .led_current_code);

/* test/semr_regs_test.sv */
// self-checking bench of the register bank
// assumes semr_host as apb master; the pin input is driven here
module semr_regs_test
    import semr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, clk_en = 1, gpio_i = 0;
    logic        psel, penable, pwrite, pready, pslverr, osc_enable;
    logic        spectral_measure_enable, wait_enable, sensor_mux_busy;
    logic        gpio_o, gpio_oe_n, led_driver_pin;
    logic [6:0]  led_current_code;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [31:0] exp_q[$];
    logic [7:0]  v;
    int          miscompares = 0, n_checks = 0, seed = 70214, i;
    always #4 pclk = ~pclk;
    semr_host host_u (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
    semr_regs dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .osc_enable, .spectral_measure_enable, .wait_enable,
        .sensor_mux_busy, .gpio_i, .gpio_o, .gpio_oe_n, .led_driver_pin, .led_current_code);
    // ====
    // checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv, input string what);
        n_checks++;
        if (seen !== expv)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic stop_test;
        if (miscompares == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // the extra edge lets the write land before outputs are looked at
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, 32'(a), 32'(d), r);
        @(posedge pclk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host_u.xfer(1'b0, 32'(a), 32'h0, r);
    endtask
    // unmapped words must answer with an error, mapped ones without
    always @(posedge pclk)
    begin
        if (psel && penable && pready)
            chk(pslverr, 32'(paddr != SEMR_ADDR_POWER_MEASURE && paddr != SEMR_ADDR_GENERAL_PIN
                && paddr != SEMR_ADDR_LED_CURRENT_CODE), "pslverr");
        if (psel && penable && pready && !pwrite)
            chk(prdata, exp_q.size() ? exp_q.pop_front() : 32'hx, "prdata");
    end
    initial
    begin
        #200us;
        miscompares++;
        stop_test();
    end
    // ====
    // scenarios
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(SEMR_ADDR_POWER_MEASURE, 32'h00);
        rd(SEMR_ADDR_GENERAL_PIN, 32'h02);
        rd(SEMR_ADDR_LED_CURRENT_CODE, 32'h04);
        wr(SEMR_ADDR_POWER_MEASURE, 8'h01);
        chk(osc_enable, 1, "osc_enable");
        for (i = 0; i < 16; i++)
        begin
            v = 8'(i);
            gpio_i <= 1'($random(seed));
            wr(SEMR_ADDR_GENERAL_PIN, v);
            chk(gpio_o, v[1] ^ v[3], "gpio_o");
            chk(gpio_oe_n, v[2], "gpio_oe_n");
            repeat (3) @(posedge pclk);
            rd(SEMR_ADDR_GENERAL_PIN, {28'h0, v[3:1], v[2] & gpio_i});
        end
        for (i = 0; i < 3; i++)
        begin
            v = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($random(seed));
            wr(SEMR_ADDR_LED_CURRENT_CODE, v);
            chk(led_current_code, v[6:0], "led_current_code");
            chk(led_driver_pin, v[7], "led_driver_pin");
            rd(SEMR_ADDR_LED_CURRENT_CODE, 32'(v));
        end
        wr(SEMR_ADDR_POWER_MEASURE, 8'h0b);
        chk(spectral_measure_enable, 1, "spectral_measure_enable");
        chk(wait_enable, 1, "wait_enable");
        wr(SEMR_ADDR_POWER_MEASURE, 8'h01);
        chk(wait_enable, 0, "wait_enable");
        chk(spectral_measure_enable, 0, "spectral_measure_enable");
        wr(SEMR_ADDR_POWER_MEASURE, 8'h11);
        rd(SEMR_ADDR_POWER_MEASURE, 32'h11);
        i = 0;
        while (sensor_mux_busy !== 1'b0 && i < 100)
        begin
            @(posedge pclk);
            i++;
        end
        rd(SEMR_ADDR_POWER_MEASURE, 32'h01);
        wr(SEMR_ADDR_LED_CURRENT_CODE, 8'h80);
        clk_en <= 1'b0;
        wr(SEMR_ADDR_LED_CURRENT_CODE, 8'h00);
        clk_en <= 1'b1;
        rd(SEMR_ADDR_LED_CURRENT_CODE, 32'h80);
        wr(10'h204, 8'h5a);
        rd(10'h204, 32'h0);
        wr(SEMR_ADDR_POWER_MEASURE, 8'h00);
        chk(osc_enable, 0, "osc_enable");
        chk(led_driver_pin, 0, "led_driver_pin");
        stop_test();
    end
endmodule
